// ===== shared/fpa_pkg.sv
// Contract
// - Bus fault bit5, data fault bit7 high.
// - Heartbeat output on low byte bit0.
// - Done bit6, session-on bit7 low byte.
// - Controller requests session before any transfer.
// - Session request unlocked gives session-on flag.
// - Controller sets address, value, then commit.
// - Done flag only after accepted transfer.
// - Address 0x2100 stores all, value below 60000.
// - Controller sends password to 0x2200 first.
// - Password set refuses writes until unlocked.
// - Unlock holds while request; clear re-arms.
// - Three wrong passwords lock, session-on clears.
// - Lockout lasts until restart only.
// - Written values checked against parameter limits.
// - Values travel as scaled integers.
// - Selection options travel as integer codes.
// - Accepted changes take effect at once.
// - Controller should clear enable before transfer.
// - Sensor monitoring on/auto deactivates on faults.
// - Solenoid wiring fault deactivates output stage.
// - Power-up data error holds output until save.
// - Request bit7, commit bit6 of control low.
// - Value is 32-bit word, MSB first, bytes 28-31.
package fpa_pkg;
   // -----------------------------------------------------------------
   // Process image layout
   // -----------------------------------------------------------------
   localparam logic [3:0]  FPA_STATUS_WORD_TWO_OFS = 4'h2;
   localparam int          FPA_SW2_BUS_FAULT_BIT   = 13;
   localparam int          FPA_SW2_DATA_FAULT_BIT  = 15;
   localparam int          FPA_SW2_HEARTBEAT_BIT   = 0;
   localparam int          FPA_SW2_DONE_BIT        = 6;
   localparam int          FPA_SW2_SESSION_ON_BIT  = 7;
   localparam int          FPA_CW_ENABLE_BIT       = 15;
   localparam int          FPA_CW_HEARTBEAT_BIT    = 8;
   localparam int          FPA_CW_COMMIT_BIT       = 6;
   localparam int          FPA_CW_REQUEST_BIT      = 7;
   localparam int          FPA_VALUE_FIRST_BYTE    = 28;
   // -----------------------------------------------------------------
   // Special addresses and limits
   // -----------------------------------------------------------------
   localparam logic [15:0] FPA_ADDR_STORE          = 16'h2100;
   localparam logic [15:0] FPA_ADDR_UNLOCK         = 16'h2200;
   localparam logic [31:0] FPA_STORE_VALUE_LIMIT   = 32'h0000ea60;
   localparam logic [1:0]  FPA_MAX_TRIES           = 2'h3;
   localparam int          FPA_PARAM_COUNT         = 16;
   localparam logic [15:0] FPA_SENSOR_SELECT_ADDR  = 16'h0000;
   localparam logic [31:0] FPA_SENSOR_SELECT_MAX   = 32'h00000002;
   localparam logic [31:0] FPA_PARAM_LIMIT_DEFAULT = 32'h00002710;
   localparam logic [31:0] FPA_PARAM_RESET         = 32'h00000000;
   localparam logic [1:0]  FPA_SENSOR_OFF          = 2'h0;
   // -----------------------------------------------------------------
   // Host register map (AXI4-Lite byte addresses)
   // -----------------------------------------------------------------
   localparam logic [3:0]  FPA_REG_CMD             = 4'h0;
   localparam logic [3:0]  FPA_REG_ADDR            = 4'h4;
   localparam logic [3:0]  FPA_REG_VALUE           = 4'h8;
   localparam logic [3:0]  FPA_REG_STATUS          = 4'hc;
   localparam int          FPA_CMD_GO_BIT          = 0;
   localparam int          FPA_CMD_SESSION_BIT     = 1;
   localparam int          FPA_CMD_ENABLE_BIT      = 2;
   localparam logic [1:0]  FPA_RESP_OKAY           = 2'h0;
   localparam logic [1:0]  FPA_RESP_SLVERR         = 2'h2;
   localparam logic [7:0]  FPA_DONE_TIMEOUT        = 8'h40;
   localparam logic [7:0]  FPA_DONE_LATENCY        = 8'h03;
endpackage

// ===== shared/fpa_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Cyclic process image between the controller and the pump module.
interface fpa_link_if;
   logic [15:0] control_word;
   logic [15:0] param_addr;
   logic [31:0] param_value_out;
   logic [15:0] status_word_two;
   logic [7:0]  value_bytes [0:3];
   modport ctrl (output control_word, output param_addr,
                 output param_value_out,
                 input status_word_two, input value_bytes);
   modport dev  (input control_word, input param_addr,
                 input param_value_out,
                 output status_word_two, output value_bytes);
endinterface
`default_nettype wire

// ===== design/fpa_device.sv
`timescale 1ns/1ps
`default_nettype none
// Device end: session, password, store and fault handling.
module fpa_device
   import fpa_pkg::*;
(
   input  wire logic              REF_CLK,
   input  wire logic              SRST,
   fpa_link_if.dev                LINK,
   input  wire logic              PASSWORD_SET,
   input  wire logic [31:0]       PASSWORD,
   input  wire logic              NVM_DATA_ERROR,
   input  wire logic              BUS_FAULT,
   input  wire logic              ANALOG_FAULT,
   input  wire logic              TRANSDUCER_FAULT,
   input  wire logic              SOLENOID_FAULT,
   output logic                   STORE_PULSE,
   output logic [1:0]             SENSOR_MONITOR_SELECT,
   output logic                   OUTPUT_ENABLE,
   output logic                   STAGE_ENABLE
);
   logic [31:0] params_q [0:FPA_PARAM_COUNT-1];
   logic        commit_q;
   logic        done_q;
   logic        unlocked_q;
   logic        locked_q;
   logic [1:0]  fails_q;
   logic        data_err_q;
   logic        err_seen_q;
   logic        store_q;
   logic        fault_q;
   logic        stage_fault_q;
   logic        request;
   logic        commit_edge;
   logic        session_on;
   logic [15:0] addr;
   logic [31:0] value;
   logic        write_ok;
   logic        store_ok;
   logic        unlock_try;

   // Limit check shared by every plain parameter write.
   function automatic logic in_limits(input logic [15:0] a,
                                      input logic [31:0] v);
      if (a == FPA_SENSOR_SELECT_ADDR)
         in_limits = (v <= FPA_SENSOR_SELECT_MAX);
      else
         in_limits = (a < 16'(FPA_PARAM_COUNT)) &&
                     (v <= FPA_PARAM_LIMIT_DEFAULT);
   endfunction

   // -----------------------------------------------------------------
   // Handshake decode
   // -----------------------------------------------------------------
   // Only the rising edge of commit starts a transfer, so a held bit
   // does not repeat the write every cycle.
   assign request     = LINK.control_word[FPA_CW_REQUEST_BIT];
   assign commit_edge = LINK.control_word[FPA_CW_COMMIT_BIT] & ~commit_q;
   assign addr        = LINK.param_addr;
   assign value       = LINK.param_value_out;
   assign session_on  = request & ~locked_q;
   assign unlock_try  = commit_edge & session_on &
                        (addr == FPA_ADDR_UNLOCK);
   assign store_ok    = commit_edge & session_on &
                        (addr == FPA_ADDR_STORE) &
                        (value < FPA_STORE_VALUE_LIMIT) &
                        (unlocked_q | ~PASSWORD_SET);
   assign write_ok    = commit_edge & session_on &
                        (unlocked_q | ~PASSWORD_SET) &
                        in_limits(addr, value);

   // Commit edge tracker.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         commit_q <= 1'b0;
      end else begin
         commit_q <= LINK.control_word[FPA_CW_COMMIT_BIT];
      end
   end

   // Done flag: set by an accepted transfer, dropped by a new commit that is refused.
   always_ff @(posedge REF_CLK) begin
      if (SRST || !request) begin
         done_q <= 1'b0;
      end else if (write_ok || store_ok ||
                   (unlock_try && value == PASSWORD)) begin
         done_q <= 1'b1;
      end else if (commit_edge) begin
         done_q <= 1'b0;
      end
   end

   // Unlock state; dropping the session request re-arms protection.
   always_ff @(posedge REF_CLK) begin
      if (SRST || !request) begin
         unlocked_q <= 1'b0;
      end else if (unlock_try && value == PASSWORD) begin
         unlocked_q <= 1'b1;
      end
   end

   // Wrong attempts counter; only reset (a restart) clears the lock.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         fails_q  <= 2'h0;
         locked_q <= 1'b0;
      end else if (unlock_try && value != PASSWORD) begin
         fails_q <= fails_q + 2'h1;
         if (fails_q + 2'h1 == FPA_MAX_TRIES)
            locked_q <= 1'b1;
      end
   end

   // Parameter store; the new value is live on the next cycle.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         for (int i = 0; i < FPA_PARAM_COUNT; i++)
            params_q[i] <= FPA_PARAM_RESET;
      end else if (write_ok) begin
         params_q[addr[3:0]] <= value;
      end
   end

   // Store pulse and power-up data error, which only a save clears.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         store_q    <= 1'b0;
         data_err_q <= 1'b0;
         err_seen_q <= 1'b0;
      end else begin
         store_q    <= store_ok;
         err_seen_q <= 1'b1;
         if (!err_seen_q && NVM_DATA_ERROR)
            data_err_q <= 1'b1;
         else if (store_ok)
            data_err_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Fault monitoring
   // -----------------------------------------------------------------
   // Faults are registered so the output gate is glitch free.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         fault_q       <= 1'b0;
         stage_fault_q <= 1'b0;
      end else begin
         fault_q <= (params_q[0][1:0] != FPA_SENSOR_OFF) &&
                    (ANALOG_FAULT || TRANSDUCER_FAULT);
         stage_fault_q <= SOLENOID_FAULT;
      end
   end

   // Status image and value feedback, all from flip-flops.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         LINK.status_word_two <= 16'h0000;
         for (int b = 0; b < 4; b++)
            LINK.value_bytes[b] <= 8'h00;
      end else begin
         LINK.status_word_two <= 16'h0000;
         LINK.status_word_two[FPA_SW2_BUS_FAULT_BIT]  <= BUS_FAULT;
         LINK.status_word_two[FPA_SW2_DATA_FAULT_BIT] <= data_err_q;
         LINK.status_word_two[FPA_SW2_HEARTBEAT_BIT]  <=
            LINK.control_word[FPA_CW_HEARTBEAT_BIT];
         LINK.status_word_two[FPA_SW2_DONE_BIT]       <= done_q;
         LINK.status_word_two[FPA_SW2_SESSION_ON_BIT] <= session_on;
         for (int b = 0; b < 4; b++)
            LINK.value_bytes[b] <=
               params_q[addr[3:0]][31-8*b -: 8];
      end
   end

   assign STORE_PULSE           = store_q;
   assign SENSOR_MONITOR_SELECT = params_q[0][1:0];
   assign OUTPUT_ENABLE         = ~fault_q & ~stage_fault_q & ~data_err_q;
   assign STAGE_ENABLE          = ~stage_fault_q;
endmodule
`default_nettype wire

// ===== design/fpa_controller.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Controller end: AXI4-Lite slave that runs one parameter handshake.
module fpa_controller
   import fpa_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   fpa_link_if.ctrl         LINK,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic             HEARTBEAT_OUT
);
   typedef enum logic [1:0] {FPA_IDLE, FPA_COMMIT, FPA_WAIT} fpa_state_t;
   fpa_state_t  state_q;
   logic [2:0]  cmd_q;
   logic [15:0] addr_q;
   logic [31:0] value_q;
   logic        aw_q, w_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        busy_q, ok_q, fail_q;
   logic [7:0]  wait_q;
   logic        hb_q;
   logic        wr_fire;
   logic [31:0] value_rd;

   assign S_AXI_AWREADY = ~aw_q & ~S_AXI_BVALID;
   assign S_AXI_WREADY  = ~w_q & ~S_AXI_BVALID;
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign wr_fire       = aw_q & w_q & ~S_AXI_BVALID;
   // The value arrives most significant byte first.
   assign value_rd = {LINK.value_bytes[0], LINK.value_bytes[1],
                      LINK.value_bytes[2], LINK.value_bytes[3]};

   // -----------------------------------------------------------------
   // AXI4-Lite write path
   // -----------------------------------------------------------------
   // Address and data are latched apart, so either may come first.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= 4'h0;
         wdata_q      <= 32'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= FPA_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q     <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_q     <= 1'b1;
            wdata_q <= S_AXI_WDATA;
         end
         if (wr_fire) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (awaddr_q == FPA_REG_STATUS) ?
                            FPA_RESP_SLVERR : FPA_RESP_OKAY;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Order registers. Any nonzero byte strobe writes the full word; all-zero strobes write nothing.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cmd_q   <= 3'h0;
         addr_q  <= 16'h0;
         value_q <= 32'h0;
      end else begin
         if (wr_fire && S_AXI_WSTRB != 4'h0) begin
            case (awaddr_q)
               FPA_REG_CMD:   cmd_q   <= wdata_q[2:0];
               FPA_REG_ADDR:  addr_q  <= wdata_q[15:0];
               FPA_REG_VALUE: value_q <= wdata_q;
               default: ;
            endcase
         end
         if (state_q == FPA_WAIT && (ok_q || fail_q))
            cmd_q[FPA_CMD_GO_BIT] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Parameter handshake
   // -----------------------------------------------------------------
   // A transfer waits for the session-on flag, then raises commit and
   // waits a bounded time for done; silence counts as not performed.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_q <= FPA_IDLE;
         busy_q  <= 1'b0;
         ok_q    <= 1'b0;
         fail_q  <= 1'b0;
         wait_q  <= 8'h0;
      end else begin
         case (state_q)
            FPA_IDLE: begin
               if (cmd_q[FPA_CMD_GO_BIT] &&
                   LINK.status_word_two[FPA_SW2_SESSION_ON_BIT]) begin
                  state_q <= FPA_COMMIT;
                  busy_q  <= 1'b1;
                  ok_q    <= 1'b0;
                  fail_q  <= 1'b0;
                  wait_q  <= 8'h0;
               end
            end
            FPA_COMMIT: begin
               state_q <= FPA_WAIT;
            end
            FPA_WAIT: begin
               wait_q <= wait_q + 8'h1;
               if (wait_q >= FPA_DONE_LATENCY &&
                   LINK.status_word_two[FPA_SW2_DONE_BIT]) begin
                  ok_q <= 1'b1;
               end else if (wait_q == FPA_DONE_TIMEOUT) begin
                  fail_q <= 1'b1;
               end
               if (ok_q || fail_q) begin
                  state_q <= FPA_IDLE;
                  busy_q  <= 1'b0;
               end
            end
            default: state_q <= FPA_IDLE;
         endcase
      end
   end

   // Output image; the enable bit is dropped while a transfer runs.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         LINK.control_word    <= 16'h0000;
         LINK.param_addr      <= 16'h0000;
         LINK.param_value_out <= 32'h0;
         hb_q                 <= 1'b0;
      end else begin
         hb_q <= ~hb_q;
         LINK.control_word <= 16'h0000;
         LINK.control_word[FPA_CW_HEARTBEAT_BIT] <= ~hb_q;
         LINK.control_word[FPA_CW_REQUEST_BIT] <=
            cmd_q[FPA_CMD_SESSION_BIT];
         LINK.control_word[FPA_CW_ENABLE_BIT] <=
            cmd_q[FPA_CMD_ENABLE_BIT] & ~busy_q;
         LINK.control_word[FPA_CW_COMMIT_BIT] <=
            (state_q == FPA_WAIT) && !ok_q && !fail_q;
         LINK.param_addr      <= addr_q;
         LINK.param_value_out <= value_q;
      end
   end

   // Read path; unmapped addresses read zero with OKAY.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0;
         S_AXI_RRESP  <= FPA_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= FPA_RESP_OKAY;
         case (S_AXI_ARADDR)
            FPA_REG_CMD:    S_AXI_RDATA <= {29'h0, cmd_q};
            FPA_REG_ADDR:   S_AXI_RDATA <= {16'h0, addr_q};
            FPA_REG_VALUE:  S_AXI_RDATA <= value_rd;
            FPA_REG_STATUS: S_AXI_RDATA <= {13'h0, fail_q, ok_q, busy_q,
                                            LINK.status_word_two};
            default:        S_AXI_RDATA <= 32'h0;
         endcase
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   assign HEARTBEAT_OUT = hb_q;
endmodule
`default_nettype wire

// ===== testbench/fpa_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the process image between the two ends; one clock domain.
module fpa_link_monitor (
   input wire logic        REF_CLK,
   input wire logic        SRST,
   input wire logic [15:0] control_word,
   input wire logic [15:0] param_addr,
   input wire logic [31:0] param_value_out,
   input wire logic [15:0] status_word_two
);
   // ----------------------------------------------------------------
   // Link assertions
   // ----------------------------------------------------------------
   default clocking mon_cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   // The echo lags the controller bit by exactly one register stage.
   heartbeat_echo_a: assert property (
      status_word_two[0] == $past(control_word[8]))
      else $error("heartbeat echo wrong");
   done_after_commit_a: assert property (
      $rose(status_word_two[6]) |-> $past(control_word[6]) ||
      $past(control_word[6], 2) || $past(control_word[6], 3))
      else $error("done flag without commit");
   session_needs_req_a: assert property (
      status_word_two[7] |-> $past(control_word[7]) ||
      $past(control_word[7], 2) || $past(control_word[7], 3))
      else $error("session flag without request");
   done_clears_a: assert property (
      $fell(control_word[7]) |-> ##[1:3] !status_word_two[6])
      else $error("done flag outlives session");
   commit_in_session_a: assert property (
      $rose(control_word[6]) |-> control_word[7])
      else $error("commit outside session");
   payload_ahead_a: assert property (
      $rose(control_word[6]) |->
      $stable(param_addr) && $stable(param_value_out))
      else $error("payload changed with commit");
   payload_stable_a: assert property (
      control_word[6] && $past(control_word[6]) |->
      $stable(param_addr) && $stable(param_value_out))
      else $error("payload moved during commit");
   enable_off_a: assert property (
      control_word[6] |-> !control_word[15])
      else $error("enable set in commit");
   // Unused status bits must read zero so the far side can mask them.
   reserved_zero_a: assert property (
      status_word_two[14] == 1'b0 && status_word_two[12:8] == 5'h00 &&
      status_word_two[5:1] == 5'h00)
      else $error("reserved status bit set");

   // ----------------------------------------------------------------
   // Coverage of the main flows
   // ----------------------------------------------------------------
   done_seen_c: cover property ($rose(status_word_two[6]));
   session_seen_c: cover property ($rose(status_word_two[7]));
   lock_seen_c: cover property (
      $fell(status_word_two[7]) && control_word[7]);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fpa_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic        ref_clk = 1'b0, srst = 1'b1;
   logic        pw_set = 1'b0, nvm_err = 1'b0, bus_flt = 1'b0;
   logic        ana_flt = 1'b0, xdcr_flt = 1'b0, sol_flt = 1'b0;
   logic [31:0] pw = 32'h0000beef;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp, sel_code;
   logic        store_pulse, out_en, stage_en, hb_out;
   int          bad_count = 0, samples_checked = 0, store_cnt = 0;

   fpa_link_if link_inst ();
   fpa_device fpa_device_inst (.REF_CLK(ref_clk), .SRST(srst),
      .LINK(link_inst), .PASSWORD_SET(pw_set), .PASSWORD(pw),
      .NVM_DATA_ERROR(nvm_err), .BUS_FAULT(bus_flt),
      .ANALOG_FAULT(ana_flt), .TRANSDUCER_FAULT(xdcr_flt),
      .SOLENOID_FAULT(sol_flt), .STORE_PULSE(store_pulse),
      .SENSOR_MONITOR_SELECT(sel_code), .OUTPUT_ENABLE(out_en),
      .STAGE_ENABLE(stage_en));
   fpa_controller fpa_controller_inst (.REF_CLK(ref_clk), .SRST(srst),
      .LINK(link_inst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .HEARTBEAT_OUT(hb_out));
   fpa_link_monitor fpa_link_monitor_inst (.REF_CLK(ref_clk),
      .SRST(srst), .control_word(link_inst.control_word),
      .param_addr(link_inst.param_addr),
      .param_value_out(link_inst.param_value_out),
      .status_word_two(link_inst.status_word_two));

   // Free-running clock and a count of store pulses, which last one cycle.
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (store_pulse === 1'b1) begin
         store_cnt <= store_cnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Address and data are offered together; each drops once taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge ref_clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge ref_clk);
         if (awvalid && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge ref_clk);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge ref_clk);
      v = rdata;
      rready <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic session(input logic on);
      wr(FPA_REG_CMD, {30'h0, on, 1'b0});
      repeat (8) @(posedge ref_clk);
   endtask
   // One handshake; ok selects whether the device must accept it.
   task automatic xfer(input logic [15:0] a, input logic [31:0] v,
                       input logic ok, input logic en);
      logic [31:0] st;
      wr(FPA_REG_ADDR, {16'h0000, a});
      wr(FPA_REG_VALUE, v);
      wr(FPA_REG_CMD, {29'h0, en, 1'b1, 1'b1});
      do rd(FPA_REG_STATUS, st); while (st[16] === 1'b1);
      chk(32'(st[18:17]), ok ? 32'h1 : 32'h2);
      chk(32'(st[6]), 32'(ok));
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic end_sim();
      $display("Compared %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      rd(FPA_REG_STATUS, d);
      chk(d & 32'hfffffffe, 32'h0);
      wr(FPA_REG_STATUS, 32'h1);
      chk(32'(resp), 32'(FPA_RESP_SLVERR));
      bus_flt <= 1'b1;
      settle();
      rd(FPA_REG_STATUS, d);
      chk(32'(d[13]), 32'h1);
      bus_flt <= 1'b0;
      $display("Test status word finished");
      session(1'b1);
      rd(FPA_REG_STATUS, d);
      chk(32'(d[7]), 32'h1);
      xfer(16'h0001, 32'd1234, 1'b1, 1'b0);
      rd(FPA_REG_VALUE, d);
      chk(d, 32'd1234);
      xfer(16'h0001, 32'd10001, 1'b0, 1'b0);
      rd(FPA_REG_VALUE, d);
      chk(d, 32'd1234);
      // Enable raised: the new value must be visible with no restart.
      xfer(16'h0001, 32'd10000, 1'b1, 1'b1);
      rd(FPA_REG_VALUE, d);
      chk(d, 32'd10000);
      xfer(16'h0010, 32'd5, 1'b0, 1'b0);
      xfer(16'h0000, 32'd3, 1'b0, 1'b0);
      for (int i = 2; i >= 0; i--) begin
         xfer(16'h0000, 32'(i), 1'b1, 1'b0);
         chk(32'(sel_code), 32'(i));
      end
      $display("Test transfers finished");
      ana_flt <= 1'b1;
      settle();
      chk(32'(out_en), 32'h1);
      xfer(16'h0000, 32'd1, 1'b1, 1'b0);
      settle();
      chk(32'(out_en), 32'h0);
      ana_flt <= 1'b0;
      xdcr_flt <= 1'b1;
      settle();
      chk(32'(out_en), 32'h0);
      xdcr_flt <= 1'b0;
      sol_flt <= 1'b1;
      settle();
      chk(32'(out_en), 32'h0);
      chk(32'(stage_en), 32'h0);
      sol_flt <= 1'b0;
      settle();
      chk(32'(stage_en), 32'h1);
      d = 32'(store_cnt);
      xfer(FPA_ADDR_STORE, 32'd59999, 1'b1, 1'b0);
      xfer(FPA_ADDR_STORE, 32'd60000, 1'b0, 1'b0);
      chk(32'(store_cnt) - d, 32'h1);
      $display("Test faults and store finished");
      nvm_err <= 1'b1;
      do_reset();
      nvm_err <= 1'b0;
      settle();
      rd(FPA_REG_STATUS, d);
      chk(32'(d[15]), 32'h1);
      chk(32'(out_en), 32'h0);
      session(1'b1);
      xfer(FPA_ADDR_STORE, 32'h0, 1'b1, 1'b0);
      settle();
      rd(FPA_REG_STATUS, d);
      chk(32'(d[15]), 32'h0);
      chk(32'(out_en), 32'h1);
      $display("Test data error finished");
      pw_set <= 1'b1;
      do_reset();
      session(1'b1);
      xfer(16'h0001, 32'd7, 1'b0, 1'b0);
      xfer(FPA_ADDR_UNLOCK, pw, 1'b1, 1'b0);
      xfer(16'h0001, 32'd7, 1'b1, 1'b0);
      session(1'b0);
      session(1'b1);
      xfer(16'h0001, 32'd8, 1'b0, 1'b0);
      repeat (3) xfer(FPA_ADDR_UNLOCK, ~pw, 1'b0, 1'b0);
      settle();
      rd(FPA_REG_STATUS, d);
      chk(32'(d[7]), 32'h0);
      xfer(FPA_ADDR_UNLOCK, pw, 1'b0, 1'b0);
      session(1'b0);
      session(1'b1);
      rd(FPA_REG_STATUS, d);
      chk(32'(d[7]), 32'h0);
      do_reset();
      session(1'b1);
      rd(FPA_REG_STATUS, d);
      chk(32'(d[7]), 32'h1);
      xfer(FPA_ADDR_UNLOCK, pw, 1'b1, 1'b0);
      $display("Test password finished");
      end_sim();
   end

   // Whole run needs well under ten thousand cycles.
   initial begin
      repeat (50000) @(posedge ref_clk);
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
endmodule
`default_nettype wire
